// ### design/stepper_stall_detect.v
// Stall detector: sample delay, back EMF scaling, threshold compare, step count.
// Assumes back EMF arrives as a synchronous 12-bit code; step and external stall are pins.
`include "stall_detect_consts.vh"
module stepper_stall_detect #(
    parameter BEMF_W = 12
) (
    input  wire              ref_clk,
    input  wire              resetn,
    input  wire [2:0]        reg_addr,
    input  wire [11:0]       reg_wdata,
    input  wire              reg_write,
    input  wire              reg_read,
    output reg  [11:0]       reg_rdata,
    input  wire              step_pin,
    input  wire [BEMF_W-1:0] bemf_code,
    input  wire              ext_stall_n,
    output reg               stall_out_n,
    output reg               bemf_out_n,
    output wire              irq
);
    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_CMP  = 3'b100;

    reg  [11:0] control_config;
    reg  [11:0] current_scale_config;
    reg  [11:0] stall_detect_config;
    reg  [1:0]  irq_status;
    reg  [1:0]  irq_mask;
    reg  [2:0]  state;
    reg  [9:0]  wait_us;
    reg  [3:0]  below_count;
    reg         step_prev;
    reg         internal_stall_n;
    wire        tick;
    wire        step_level;

    wire        stall_source_select = control_config[`CTRL_SRC_BIT];
    wire [2:0]  bemf_sample_delay   = current_scale_config[`DELAY_MSB:`DELAY_LSB];
    wire [7:0]  stall_threshold     = stall_detect_config[`THR_MSB:`THR_LSB];
    wire [1:0]  stall_step_count    = stall_detect_config[`CNT_MSB:`CNT_LSB];
    wire [1:0]  bemf_divider        = stall_detect_config[`DIV_MSB:`DIV_LSB];

    us_tick u_tick (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .tick    (tick)
    );

    pin_sync u_step (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .pin     (step_pin),
        .level   (step_level)
    );

    function [9:0] delay_us;
        input [2:0] code;
        begin
            case (code)
                3'h0:    delay_us = `DELAY_US_0;
                3'h1:    delay_us = `DELAY_US_1;
                3'h2:    delay_us = `DELAY_US_2;
                3'h3:    delay_us = `DELAY_US_3;
                3'h4:    delay_us = `DELAY_US_4;
                3'h5:    delay_us = `DELAY_US_5;
                3'h6:    delay_us = `DELAY_US_6;
                default: delay_us = `DELAY_US_7;
            endcase
        end
    endfunction

    // Code 00 divides by 32, each step up halves the divisor
    function [BEMF_W-1:0] scale_bemf;
        input [BEMF_W-1:0] raw;
        input [1:0]        div;
        begin
            scale_bemf = raw >> (3'h5 - {1'b0, div});
        end
    endfunction

    function [3:0] steps_needed;
        input [1:0] code;
        begin
            case (code)
                2'h0:    steps_needed = 4'h1;
                2'h1:    steps_needed = 4'h2;
                2'h2:    steps_needed = 4'h4;
                default: steps_needed = 4'h8;
            endcase
        end
    endfunction

    wire             step_rise = step_level & ~step_prev;
    wire [BEMF_W-1:0] scaled   = scale_bemf(bemf_code, bemf_divider);
    // Larger threshold or smaller divider setting means more speed needed to stay above
    wire             below     = scaled < {{(BEMF_W-8){1'b0}}, stall_threshold};
    wire [3:0]       need      = steps_needed(stall_step_count);
    // Against need-1, since below_count does not yet include the current below-threshold step
    wire             reached   = below_count >= need - 4'h1;

    reg  [2:0] next_state;
    reg  [3:0] next_count;
    reg        stall_event;
    reg        sample_event;

    always @* begin
        next_state   = state;
        next_count   = below_count;
        stall_event  = 1'b0;
        sample_event = 1'b0;
        case (state)
            ST_IDLE: begin
                if (step_rise)
                    next_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (tick && wait_us == delay_us(bemf_sample_delay) - 10'd1)
                    next_state = ST_CMP;
            end
            ST_CMP: begin
                next_state = ST_IDLE;
                if (below) begin
                    sample_event = 1'b1;
                    if (below_count != 4'hF)
                        next_count = below_count + 4'h1;
                    if (reached)
                        stall_event = 1'b1;
                end else begin
                    next_count = 4'h0;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state       <= ST_IDLE;
            wait_us     <= 10'd0;
            below_count <= 4'h0;
            step_prev   <= 1'b0;
            stall_out_n <= 1'b1;
            internal_stall_n <= 1'b1;
            bemf_out_n  <= 1'b1;
        end else begin
            state       <= next_state;
            below_count <= next_count;
            step_prev   <= step_level;
            if (state != ST_WAIT)
                wait_us <= 10'd0;
            else if (tick)
                wait_us <= wait_us + 10'd1;
            if (state == ST_CMP) begin
                bemf_out_n       <= ~below;
                internal_stall_n <= ~(reached & below);
            end
            // External source passes the outside detector through one register, a cycle late
            // Back on internal, the held internal result shows, not a stale external level
            if (stall_source_select)
                stall_out_n <= ext_stall_n;
            else if (state == ST_CMP)
                stall_out_n <= ~(reached & below);
            else
                stall_out_n <= internal_stall_n;
        end
    end

    // Registers; status is cleared by its read, a same-cycle event still sets
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            control_config       <= `CONTROL_RESET;
            current_scale_config <= `CURRENT_RESET;
            stall_detect_config  <= `STALL_RESET;
            irq_status           <= 2'h0;
            irq_mask             <= `IRQ_MASK_RESET;
            reg_rdata            <= 12'h000;
        end else begin
            if (reg_write) begin
                case (reg_addr)
                    `ADDR_CONTROL:  control_config       <= reg_wdata;
                    `ADDR_CURRENT:  current_scale_config <= reg_wdata;
                    `ADDR_STALL:    stall_detect_config  <= reg_wdata;
                    `ADDR_IRQ_MASK: irq_mask             <= reg_wdata[1:0];
                    default: ;
                endcase
            end
            if (reg_read && reg_addr == `ADDR_IRQ_STATUS)
                irq_status <= {sample_event, stall_event & ~stall_source_select};
            else
                irq_status <= irq_status | {sample_event, stall_event & ~stall_source_select};
            if (reg_read) begin
                case (reg_addr)
                    `ADDR_CONTROL:    reg_rdata <= control_config;
                    `ADDR_CURRENT:    reg_rdata <= current_scale_config;
                    `ADDR_STALL:      reg_rdata <= stall_detect_config;
                    `ADDR_IRQ_STATUS: reg_rdata <= {10'h000, irq_status};
                    `ADDR_IRQ_MASK:   reg_rdata <= {10'h000, irq_mask};
                    default:          reg_rdata <= 12'h000;
                endcase
            end else begin
                reg_rdata <= 12'h000;
            end
        end
    end

    assign irq = |(irq_status & irq_mask);
endmodule

// ### include/stall_detect_consts.vh
// Constants for the stepper stall detector: register map, fields, resets, timing.
// Assumes a 100 MHz ref_clk and a plain register port with one-cycle read latency.
// Notes on behaviour
// - Source select bit 0 uses internal detector, 1 defers to external; resets to 0.
// - Wait the 3-bit coded sample delay, 50 to 1000 us, before sampling; reset code 001.
// - Compare scaled back EMF with 8-bit threshold in stall bits 7-0; reset 0x40.
// - Stall output low after 1, 2, 4 or 8 below-threshold steps per 2-bit count field.
// - Scale back EMF by 32, 16, 8 or 4 per bits 11-10 before compare; reset 00.
// - Raising threshold or lowering divider setting makes stall trip at higher motor speed.
`ifndef STALL_DETECT_CONSTS_VH
`define STALL_DETECT_CONSTS_VH

`define ADDR_W            3
`define DATA_W            12
`define ADDR_CONTROL      3'h0
`define ADDR_CURRENT      3'h1
`define ADDR_STALL        3'h5
`define ADDR_IRQ_STATUS   3'h6
`define ADDR_IRQ_MASK     3'h7

`define CTRL_SRC_BIT      7
`define DELAY_LSB         8
`define DELAY_MSB         10
`define THR_LSB           0
`define THR_MSB           7
`define CNT_LSB           8
`define CNT_MSB           9
`define DIV_LSB           10
`define DIV_MSB           11

`define CONTROL_RESET     12'h000
`define CURRENT_RESET     12'h100
`define STALL_RESET       12'h040
`define IRQ_MASK_RESET    2'h0

`define IRQ_STALL_BIT     0
`define IRQ_SAMPLE_BIT    1

`define CLK_MHZ           100
`define US_PER_TICK       1
`define TICK_CYCLES       (`US_PER_TICK * `CLK_MHZ)
`define DELAY_US_0        10'd50
`define DELAY_US_1        10'd100
`define DELAY_US_2        10'd200
`define DELAY_US_3        10'd300
`define DELAY_US_4        10'd400
`define DELAY_US_5        10'd600
`define DELAY_US_6        10'd800
`define DELAY_US_7        10'd1000

`endif

// ### design/us_tick.v
// Divider giving a one-cycle pulse every microsecond.
// Assumes ref_clk at the rate named in the constants header.
`include "stall_detect_consts.vh"
module us_tick #(
    parameter DIVIDE = `TICK_CYCLES
) (
    input  wire ref_clk,
    input  wire resetn,
    output reg  tick
);
    reg [7:0] count;

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            count <= 8'h00;
            tick  <= 1'b0;
        end else if (count == DIVIDE[7:0] - 8'h01) begin
            count <= 8'h00;
            tick  <= 1'b1;
        end else begin
            count <= count + 8'h01;
            tick  <= 1'b0;
        end
    end
endmodule

// ### design/pin_sync.v
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to ref_clk.
module pin_sync (
    input  wire ref_clk,
    input  wire resetn,
    input  wire pin,
    output reg  level
);
    reg s1;
    reg s2;
    reg s3;

    // First stage feeds only the second
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            s3    <= 1'b0;
            level <= 1'b0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                level <= s3;
        end
    end
endmodule

// ### tb/stepper_stall_detect_monitor.sv
// Port checker for the stall detector.
// Assumes it is bound to the top module.
module stall_detect_monitor (
    input logic        ref_clk,
    input logic        resetn,
    input logic [2:0]  reg_addr,
    input logic [11:0] reg_wdata,
    input logic        reg_write,
    input logic        reg_read,
    input logic [11:0] reg_rdata,
    input logic        ext_stall_n,
    input logic        stall_out_n,
    input logic        bemf_out_n,
    input logic        irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        src, src_q, mask_zero;
    logic [1:0]  cnt;
    logic [15:0] gap;
    // Two cycles of a steady source bit, so a switch is never judged
    wire         intl = !src && !src_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            {src, src_q, cnt, mask_zero} <= 5'h01;
            gap <= 16'hFFFF;
        end else begin
            src_q <= src;
            gap <= $changed(bemf_out_n) ? 16'h0000 : gap + 16'(gap != 16'hFFFF);
            if (reg_write && reg_addr == 3'h0) src <= reg_wdata[7];
            if (reg_write && reg_addr == 3'h5) cnt <= reg_wdata[9:8];
            if (reg_write && reg_addr == 3'h7) mask_zero <= reg_wdata[1:0] == 2'h0;
        end
    end
    rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 12'h000)
        else $error("read data outside its slot");
    ext_follow_a: assert property (src && src_q |-> stall_out_n == $past(ext_stall_n))
        else $error("stall output not following external input");
    clear_on_above_a: assert property (intl && $rose(bemf_out_n) |-> stall_out_n)
        else $error("stall kept after step above threshold");
    stall_below_a: assert property (intl && !stall_out_n |-> !bemf_out_n)
        else $error("stall low while last step above threshold");
    first_step_a: assert property (intl && cnt == 2'h0 && $fell(bemf_out_n) |-> !stall_out_n)
        else $error("no stall on first low step");
    compare_gap_a: assert property (intl && $changed(bemf_out_n) |-> gap >= 16'h12C0)
        else $error("compares closer than shortest delay");
    irq_mask_a: assert property (mask_zero |-> !irq)
        else $error("interrupt while fully masked");
endmodule
bind stepper_stall_detect stall_detect_monitor stall_detect_monitor_i (.ref_clk(ref_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .ext_stall_n(ext_stall_n), .stall_out_n(stall_out_n), .bemf_out_n(bemf_out_n), .irq(irq));

// ### tb/motor_model.sv
// Motor side: step pulses and winding back EMF.
// Assumes go pulses one cycle per step, far apart.
module motor_model (
    input  logic        ref_clk,
    input  logic        go,
    input  logic [11:0] level,
    input  logic [4:0]  width,
    output logic        step_pin,
    output logic [11:0] bemf_code = 12'h000
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] left = 5'h00;
    assign step_pin = left != 5'h00;
    // Back EMF held for the whole step so the late sample sees one value
    always @(posedge ref_clk) begin
        if (go) begin
            left <= width;
            bemf_code <= level;
        end else if (left != 5'h00) begin
            left <= left - 5'h01;
        end
    end
endmodule

// ### tb/stepper_stall_detect_test.sv
// Bench: registers, sample delay, compare, count, interrupt.
// Assumes the motor model supplies steps and back EMF.
module stepper_stall_detect_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, ext_stall_n = 1'b1;
    logic        go = 1'b0, msk = 1'b0;
    logic [2:0]  reg_addr = 3'h0, dly = 3'h1;
    logic [11:0] reg_wdata = 12'h000, level = 12'h000, rd;
    logic [4:0]  width = 5'h08;
    logic [1:0]  div = 2'h0, code = 2'h0;
    logic [7:0]  thr = 8'h40;
    logic [2:0]  ra [6] = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h7, 3'h2};
    logic [11:0] rv [6] = '{12'h000, 12'h100, 12'h040, 12'h000, 12'h000, 12'h000};
    wire  [11:0] reg_rdata, bemf_code;
    wire         step_pin, stall_out_n, bemf_out_n, irq;
    integer      fail_count = 0, comparisons = 0, seed = 32'hD4693E20, run = 0, i, n;
    stepper_stall_detect stepper_stall_detect_i (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .step_pin(step_pin), .bemf_code(bemf_code), .ext_stall_n(ext_stall_n),
        .stall_out_n(stall_out_n), .bemf_out_n(bemf_out_n), .irq(irq));
    motor_model motor_model_i (.ref_clk(ref_clk), .go(go), .level(level), .width(width),
        .step_pin(step_pin), .bemf_code(bemf_code));
    initial forever #5 ref_clk = ~ref_clk;
    task chk(input logic [11:0] seen, input logic [11:0] want);
        comparisons = comparisons + 1;
        if (seen !== want) begin
            fail_count = fail_count + 1;
            $display("FAIL at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task test_done;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task wr(input logic [2:0] a, input logic [11:0] d);
        @(posedge ref_clk);
        {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask
    task rdq(input logic [2:0] a);
        @(posedge ref_clk);
        {reg_addr, reg_read} <= {a, 1'b1};
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 rd = reg_rdata;
    endtask
    function automatic integer cycles(input logic [2:0] c);
        logic [9:0] us [8] = '{10'h032, 10'h064, 10'h0C8, 10'h12C, 10'h190, 10'h258, 10'h320, 10'h3E8};
        cycles = us[c] * 32'h64;
    endfunction
    function automatic logic below(input logic [11:0] v);
        below = (v / (12'd32 >> div)) < {4'h0, thr};
    endfunction
    // Cycles between steps from rpm, microsteps and step angle in hundredths of a degree
    function automatic integer step_gap(input integer rpm, input integer usteps, input integer angle_cd);
        step_gap = 100000000 / (rpm * usteps * 600 / angle_cd);
    endfunction
    task step(input logic [11:0] v);
        logic lo;
        lo = below(v);
        run = lo ? (run < 15 ? run + 1 : 15) : 0;
        @(posedge ref_clk);
        {level, go} <= {v, 1'b1};
        width <= 5'h04 + 5'(4'($random(seed)));
        @(posedge ref_clk);
        go <= 1'b0;
        for (n = 0; irq !== 1'b1 && n < cycles(dly) + 200; n = n + 1) @(posedge ref_clk);
        #1;
        if (lo && msk) chk(12'(n > cycles(dly) - 100 && n < cycles(dly) + 120), 12'h001);
        chk(12'(irq), 12'(lo && msk));
        chk(12'(bemf_out_n), 12'(!lo));
        chk(12'(stall_out_n), 12'(run < (1 << code)));
        rdq(3'h6);
        chk(12'(rd[1:0]), 12'({lo, lo && run >= (1 << code)}));
        chk(12'(irq), 12'h000);
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        wr(3'h2, 12'hFFF);
        wr(3'h6, 12'h003);
        for (i = 0; i < 6; i = i + 1) begin
            rdq(ra[i]);
            chk(rd, rv[i]);
        end
        $display("test reset values done");
        wr(3'h0, 12'h080);
        for (i = 0; i < 6; i = i + 1) begin
            @(posedge ref_clk);
            ext_stall_n <= 1'($random(seed));
            @(posedge ref_clk);
            #1 chk(12'(stall_out_n), 12'(ext_stall_n));
        end
        wr(3'h0, 12'h000);
        wr(3'h7, 12'h002);
        msk = 1'b1;
        step(12'h7E0);
        $display("test sample delay done");
        wr(3'h1, 12'h000);
        dly = 3'h0;
        // Tuning starts from the lowest threshold and divider
        for (i = 0; i < 3; i = i + 1) begin
            thr = 8'(i) * 8'h11;
            wr(3'h5, {4'h0, thr});
            step(12'h220);
        end
        $display("test threshold sweep done");
        for (i = 0; i < 10; i = i + 1) begin
            {div, code, thr} = 12'($random(seed));
            msk = 1'($random(seed));
            wr(3'h5, {div, code, thr});
            wr(3'h7, {10'h000, msk, msk});
            rdq(3'h5);
            chk(rd, {div, code, thr});
            repeat (step_gap(3000, 64, 180)) @(posedge ref_clk);
            step({1'b0, 11'($random(seed))});
        end
        $display("test random steps done");
        test_done;
    end
    initial begin
        #900000;
        fail_count = fail_count + 1;
        test_done;
    end
endmodule
